// ---- rtl/glyph_pkg.sv ----
// Shared constants for the glyph address generator and its command host.
// Assumes both ends run on one system clock.
package glyph_pkg;
  // Register offsets of the glyph table base
  localparam logic [7:0] REG_GLYPH_BASE_LOW = 8'h19;
  localparam logic [7:0] REG_GLYPH_BASE_HIGH = 8'h1A;
  // Command codes
  localparam logic [7:0] GLYPH_BASE_SET_CMD = 8'h5C;
  localparam logic [7:0] CURSOR_STEP_RIGHT_CMD = 8'h4C;
  localparam logic [7:0] CURSOR_STEP_LEFT_CMD = 8'h4D;
  localparam logic [7:0] CURSOR_STEP_UP_CMD = 8'h4E;
  localparam logic [7:0] CURSOR_STEP_DOWN_CMD = 8'h4F;
  localparam logic [7:0] CURSOR_POSITION_WRITE_CMD = 8'h46;
  localparam logic [7:0] DISPLAY_MEMORY_WRITE_CMD = 8'h42;
  // Step direction codes (low two bits of the direction command)
  localparam logic [1:0] DIR_RIGHT = 2'h0;
  localparam logic [1:0] DIR_LEFT = 2'h1;
  localparam logic [1:0] DIR_UP = 2'h2;
  localparam logic [1:0] DIR_DOWN = 2'h3;
  // User glyph code ranges
  localparam logic [7:0] REGION_ONE_FIRST = 8'h80;
  localparam logic [7:0] REGION_ONE_LAST = 8'h9F;
  localparam logic [7:0] REGION_TWO_FIRST = 8'hE0;
  localparam logic [7:0] REGION_TWO_LAST = 8'hFF;
  // Tallest glyph that still uses the short layout
  localparam logic [4:0] SHORT_GLYPH_MAX_LINES = 5'h08;
  // Reset values and the unit cursor step
  localparam logic [15:0] GLYPH_BASE_RESET = 16'h0000;
  localparam logic [15:0] CURSOR_RESET = 16'h0000;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [15:0] STEP_ONE = 16'h0001;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_DIR = 3'h1,
    H_ADR = 3'h3,
    H_LO = 3'h2,
    H_HI = 3'h6,
    H_MW = 3'h7,
    H_ROW = 3'h5
  } host_state_t;
endpackage

// ---- rtl/glyph_link_if.sv ----
// Byte link from the command host to the glyph address generator.
// Both ends sit on sys_clk; one byte per cycle, no back-pressure.
`timescale 1ns/100ps
`default_nettype none
interface glyph_link_if (
  input wire logic sys_clk
);
  logic wr_valid;
  logic wr_is_cmd;
  logic [7:0] wr_data;
  modport host (
    output wr_valid,
    output wr_is_cmd,
    output wr_data
  );
  modport device (
    input wr_valid,
    input wr_is_cmd,
    input wr_data
  );
endinterface
`default_nettype wire

// ---- rtl/glyph_ram_address_gen.sv ----
// Glyph address generator: command decoder for base, cursor and memory
// writes, plus the per-row glyph fetch address path.
// Assumes the host end keeps the byte order of each command sequence.
//
// Behaviour
// - Fetch address is base plus code plus row
// - Short layout: code at 10..3, row 2..0
// - Tall layout: code at 11..4, row 3..0
// - Row index is plain binary row number
// - Eight lines or fewer use short layout
// - Codes 80-9F, E0-FF come from glyph RAM
// - Without font ROM all codes use RAM, base zero
// - Host uses glyph RAM only in 1 bpp
// - Base set: 5Ch, low byte, high byte
// - Load: step right, cursor, write, rows ascending
// - Font ROM used only when source bit zero
`timescale 1ns/100ps
`default_nettype none
module glyph_ram_address_gen
  import glyph_pkg::*;
#(
  parameter logic [15:0] ROW_PITCH = 16'h0040
) (
  input wire logic sys_clk,
  input wire logic rst,
  glyph_link_if.device lnk,
  input wire logic font_rom_off,
  input wire logic [4:0] char_lines,
  input wire logic fetch_req,
  input wire logic [7:0] fetch_code,
  input wire logic [3:0] fetch_row,
  output logic fetch_valid_r,
  output logic fetch_from_ram_r,
  output logic [15:0] fetch_addr_r,
  output logic rom_fetch_r,
  output logic [11:0] rom_index_r,
  output logic mem_wr_en_r,
  output logic [15:0] mem_wr_addr_r,
  output logic [7:0] mem_wr_data_r,
  output logic [15:0] glyph_table_base_r,
  output logic [15:0] cursor_addr_r
);
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic pidx_r;
  logic pidx_nxt;
  logic [1:0] dir_r;
  logic [1:0] dir_nxt;
  logic [15:0] base_nxt;
  logic [15:0] cursor_nxt;
  logic mem_wr_en_nxt;
  logic [15:0] mem_wr_addr_nxt;
  logic [7:0] mem_wr_data_nxt;
  logic [15:0] step;

  // Cursor step for each display memory write
  always_comb begin
    unique case (dir_r)
      DIR_RIGHT: step = STEP_ONE;
      DIR_LEFT: step = 16'(~STEP_ONE + STEP_ONE);
      // Up and down move by one row pitch
      DIR_UP: step = 16'(~ROW_PITCH + STEP_ONE);
      DIR_DOWN: step = ROW_PITCH;
    endcase
  end

  // Link byte decode; the command register holds the last code seen
  logic cmd_byte;
  logic par_byte;
  logic dir_cmd;
  logic base_cmd_active;
  logic cursor_cmd_active;
  logic write_cmd_active;

  always_comb begin
    cmd_byte = lnk.wr_valid && lnk.wr_is_cmd;
    par_byte = lnk.wr_valid && !lnk.wr_is_cmd;
    // All four step codes share the upper six bits
    dir_cmd = lnk.wr_data[7:2] == CURSOR_STEP_RIGHT_CMD[7:2];
    base_cmd_active = cmd_r == GLYPH_BASE_SET_CMD;
    cursor_cmd_active = cmd_r == CURSOR_POSITION_WRITE_CMD;
    write_cmd_active = cmd_r == DISPLAY_MEMORY_WRITE_CMD;
  end

  // Command decoder
  always_comb begin
    cmd_nxt = cmd_r;
    pidx_nxt = pidx_r;
    dir_nxt = dir_r;
    base_nxt = glyph_table_base_r;
    cursor_nxt = cursor_addr_r;
    mem_wr_en_nxt = 1'b0;
    mem_wr_addr_nxt = mem_wr_addr_r;
    mem_wr_data_nxt = mem_wr_data_r;
    if (cmd_byte) begin
      cmd_nxt = lnk.wr_data;
      pidx_nxt = 1'b0;
      if (dir_cmd) begin
        dir_nxt = lnk.wr_data[1:0];
      end
    end else if (par_byte) begin
      // Base and cursor bytes beyond two rewrite the high byte
      pidx_nxt = 1'b1;
      if (base_cmd_active) begin
        if (!pidx_r) begin
          base_nxt[7:0] = lnk.wr_data;
        end else begin
          base_nxt[15:8] = lnk.wr_data;
        end
      end else if (cursor_cmd_active) begin
        if (!pidx_r) begin
          cursor_nxt[7:0] = lnk.wr_data;
        end else begin
          cursor_nxt[15:8] = lnk.wr_data;
        end
      end else if (write_cmd_active) begin
        // Every byte lands at the cursor, which then advances
        mem_wr_en_nxt = 1'b1;
        mem_wr_addr_nxt = cursor_addr_r;
        mem_wr_data_nxt = lnk.wr_data;
        cursor_nxt = 16'(cursor_addr_r + step);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_r <= CMD_RESET;
      pidx_r <= 1'b0;
      dir_r <= DIR_RIGHT;
      glyph_table_base_r <= GLYPH_BASE_RESET;
      cursor_addr_r <= CURSOR_RESET;
      mem_wr_en_r <= 1'b0;
      mem_wr_addr_r <= CURSOR_RESET;
      mem_wr_data_r <= CMD_RESET;
    end else begin
      cmd_r <= cmd_nxt;
      pidx_r <= pidx_nxt;
      dir_r <= dir_nxt;
      glyph_table_base_r <= base_nxt;
      cursor_addr_r <= cursor_nxt;
      mem_wr_en_r <= mem_wr_en_nxt;
      mem_wr_addr_r <= mem_wr_addr_nxt;
      mem_wr_data_r <= mem_wr_data_nxt;
    end
  end

  // Fetch path
  logic tall_layout;
  logic in_user_region;
  logic from_ram;
  logic [15:0] glyph_offset;
  logic fetch_valid_nxt;
  logic fetch_from_ram_nxt;
  logic [15:0] fetch_addr_nxt;
  logic rom_fetch_nxt;
  logic [11:0] rom_index_nxt;

  // One range comparator per user glyph region
  localparam logic [1:0][7:0] REGION_FIRST = {REGION_TWO_FIRST,
    REGION_ONE_FIRST};
  localparam logic [1:0][7:0] REGION_LAST = {REGION_TWO_LAST,
    REGION_ONE_LAST};
  wire logic [1:0] region_hit;

  for (genvar g = 0; g < 2; g++) begin : gen_region
    assign region_hit[g] = fetch_code >= REGION_FIRST[g] &&
      fetch_code <= REGION_LAST[g];
  end

  always_comb begin
    tall_layout = char_lines > SHORT_GLYPH_MAX_LINES;
    in_user_region = |region_hit;
    // Base is added either way; host keeps it zero without the ROM
    from_ram = font_rom_off || in_user_region;
    // Row bits above the layout height are dropped
    if (tall_layout) begin
      glyph_offset = {4'h0, fetch_code, fetch_row};
    end else begin
      glyph_offset = {5'h00, fetch_code, fetch_row[2:0]};
    end
    fetch_valid_nxt = fetch_req;
    fetch_from_ram_nxt = fetch_req && from_ram;
    fetch_addr_nxt = 16'(glyph_table_base_r + glyph_offset);
    // ROM path never touches display memory
    rom_fetch_nxt = fetch_req && !from_ram;
    // ROM index keeps all four row bits whatever the layout
    rom_index_nxt = {fetch_code, fetch_row};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fetch_valid_r <= 1'b0;
      fetch_from_ram_r <= 1'b0;
      fetch_addr_r <= GLYPH_BASE_RESET;
      rom_fetch_r <= 1'b0;
      rom_index_r <= 12'h000;
    end else begin
      fetch_valid_r <= fetch_valid_nxt;
      fetch_from_ram_r <= fetch_from_ram_nxt;
      fetch_addr_r <= fetch_addr_nxt;
      rom_fetch_r <= rom_fetch_nxt;
      rom_index_r <= rom_index_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/glyph_cmd_host.sv ----
// Command host: turns base-set and glyph-load requests into link bytes.
// Assumes the generator accepts one link byte every cycle.
`timescale 1ns/100ps
`default_nettype none
module glyph_cmd_host
  import glyph_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  glyph_link_if.host lnk,
  input wire logic font_rom_off,
  input wire logic one_bpp_mode,
  input wire logic op_valid,
  input wire logic op_load,
  input wire logic [15:0] op_value,
  input wire logic [4:0] op_rows,
  input wire logic row_valid,
  input wire logic [7:0] row_data,
  output logic op_ready_r,
  output logic op_refused_r,
  output logic row_ready_r
);
  host_state_t state_r;
  host_state_t state_nxt;
  logic load_r;
  logic load_nxt;
  logic [15:0] value_r;
  logic [15:0] value_nxt;
  logic [4:0] rows_r;
  logic [4:0] rows_nxt;
  logic wv_r;
  logic wv_nxt;
  logic wc_r;
  logic wc_nxt;
  logic [7:0] wd_r;
  logic [7:0] wd_nxt;
  logic refused_nxt;

  assign lnk.wr_valid = wv_r;
  assign lnk.wr_is_cmd = wc_r;
  assign lnk.wr_data = wd_r;

  always_comb begin
    state_nxt = state_r;
    load_nxt = load_r;
    value_nxt = value_r;
    rows_nxt = rows_r;
    wv_nxt = 1'b0;
    wc_nxt = 1'b0;
    wd_nxt = wd_r;
    refused_nxt = 1'b0;
    unique case (state_r)
      H_IDLE: begin
        if (op_valid) begin
          if (op_load && !one_bpp_mode) begin
            // Glyph RAM is meaningless in grey-scale modes
            refused_nxt = 1'b1;
          end else begin
            load_nxt = op_load;
            rows_nxt = op_rows;
            value_nxt = op_value;
            if (!op_load && font_rom_off) begin
              value_nxt = GLYPH_BASE_RESET;
            end
            state_nxt = op_load ? H_DIR : H_ADR;
          end
        end
      end
      H_DIR: begin
        wv_nxt = 1'b1;
        wc_nxt = 1'b1;
        wd_nxt = CURSOR_STEP_RIGHT_CMD;
        state_nxt = H_ADR;
      end
      H_ADR: begin
        wv_nxt = 1'b1;
        wc_nxt = 1'b1;
        wd_nxt = load_r ? CURSOR_POSITION_WRITE_CMD
                        : GLYPH_BASE_SET_CMD;
        state_nxt = H_LO;
      end
      H_LO: begin
        wv_nxt = 1'b1;
        wd_nxt = value_r[7:0];
        state_nxt = H_HI;
      end
      H_HI: begin
        wv_nxt = 1'b1;
        wd_nxt = value_r[15:8];
        state_nxt = (load_r && rows_r != 5'h00) ? H_MW : H_IDLE;
      end
      H_MW: begin
        wv_nxt = 1'b1;
        wc_nxt = 1'b1;
        wd_nxt = DISPLAY_MEMORY_WRITE_CMD;
        state_nxt = H_ROW;
      end
      H_ROW: begin
        if (row_valid && row_ready_r) begin
          // Rows go out in arrival order, row 0 first
          wv_nxt = 1'b1;
          wd_nxt = row_data;
          rows_nxt = 5'(rows_r - 5'h01);
          if (rows_r == 5'h01) begin
            state_nxt = H_IDLE;
          end
        end
      end
      default: state_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= H_IDLE;
      load_r <= 1'b0;
      value_r <= GLYPH_BASE_RESET;
      rows_r <= 5'h00;
      wv_r <= 1'b0;
      wc_r <= 1'b0;
      wd_r <= CMD_RESET;
      op_ready_r <= 1'b0;
      op_refused_r <= 1'b0;
      row_ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      load_r <= load_nxt;
      value_r <= value_nxt;
      rows_r <= rows_nxt;
      wv_r <= wv_nxt;
      wc_r <= wc_nxt;
      wd_r <= wd_nxt;
      op_ready_r <= state_nxt == H_IDLE;
      op_refused_r <= refused_nxt;
      row_ready_r <= state_nxt == H_ROW;
    end
  end
endmodule
`default_nettype wire

// ---- dv/glyph_link_checker.sv ----
// Assertions on the glyph link and the fetch path.
// Instantiated by the bench beside the link interface.
`timescale 1ns/100ps
`default_nettype none
module glyph_link_checker
  import glyph_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_valid,
  input wire logic wr_is_cmd,
  input wire logic [7:0] wr_data,
  input wire logic fetch_req,
  input wire logic [7:0] fetch_code,
  input wire logic [3:0] fetch_row,
  input wire logic [4:0] char_lines,
  input wire logic font_rom_off,
  input wire logic fetch_valid_r,
  input wire logic fetch_from_ram_r,
  input wire logic [15:0] fetch_addr_r,
  input wire logic rom_fetch_r,
  input wire logic [15:0] glyph_table_base_r,
  input wire logic mem_wr_en_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic cmd = wr_valid && wr_is_cmd;
  wire logic par = wr_valid && !wr_is_cmd;
  wire logic in_ram = fetch_code[7:5] == 3'h4 || fetch_code[7:5] == 3'h7;
  wire logic [15:0] short_off = {5'h00, fetch_code, fetch_row[2:0]};
  wire logic [15:0] tall_off = {4'h0, fetch_code, fetch_row};
  fetch_answer_a: assert property (fetch_req |=> fetch_valid_r)
    else $error("fetch not answered");
  short_addr_a: assert property (fetch_req && char_lines <= 5'h08 |=>
    fetch_addr_r == $past(glyph_table_base_r) + $past(short_off))
    else $error("short address wrong");
  tall_addr_a: assert property (fetch_req && char_lines > 5'h08 |=>
    fetch_addr_r == $past(glyph_table_base_r) + $past(tall_off))
    else $error("tall address wrong");
  ram_code_a: assert property (fetch_req && in_ram |=>
    fetch_from_ram_r && !rom_fetch_r) else $error("ram code misrouted");
  all_ram_a: assert property (fetch_req && font_rom_off |=>
    fetch_from_ram_r && !rom_fetch_r) else $error("rom used when off");
  rom_code_a: assert property (fetch_req && !font_rom_off &&
    !in_ram |=> rom_fetch_r && !fetch_from_ram_r)
    else $error("rom code misrouted");
  base_load_a: assert property (cmd && wr_data == GLYPH_BASE_SET_CMD
    ##1 par ##1 par |=> glyph_table_base_r ==
    {$past(wr_data), $past(wr_data, 2)}) else $error("base not loaded");
  base_params_a: assert property (cmd && wr_data == GLYPH_BASE_SET_CMD
    |=> par [*2]) else $error("base bytes missing");
  load_order_a: assert property (cmd &&
    wr_data == CURSOR_STEP_RIGHT_CMD |=> cmd &&
    wr_data == CURSOR_POSITION_WRITE_CMD)
    else $error("cursor write not next");
  row_write_a: assert property (cmd &&
    wr_data == DISPLAY_MEMORY_WRITE_CMD ##1 par |=> mem_wr_en_r)
    else $error("row not written");
  zero_base_a: assert property (font_rom_off && cmd &&
    wr_data == GLYPH_BASE_SET_CMD |=> wr_data == 8'h00 ##1 wr_data == 8'h00)
    else $error("base not zero without rom");
endmodule
`default_nettype wire

// ---- dv/glyph_ram_address_gen_test.sv ----
// Bench joining command host and generator over the link.
// Random stimulus with a fixed seed, plus corner codes.
`timescale 1ns/100ps
`default_nettype none
module glyph_ram_address_gen_test
  import glyph_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, font_rom_off = 1'b0;
  logic one_bpp_mode = 1'b1, op_valid = 1'b0, op_load = 1'b0;
  logic row_valid = 1'b0, fetch_req = 1'b0;
  logic [15:0] op_value = 16'h0000, base;
  logic [4:0] op_rows = 5'h00, char_lines = 5'h08;
  logic [7:0] row_data = 8'h00, fetch_code = 8'h00;
  logic [3:0] fetch_row = 4'h0;
  logic op_ready_r, op_refused_r, row_ready_r, fetch_valid_r, rom_fetch_r;
  logic fetch_from_ram_r, mem_wr_en_r;
  logic [11:0] rom_index_r;
  logic [15:0] fetch_addr_r, mem_wr_addr_r, glyph_table_base_r, cursor_addr_r;
  logic [7:0] mem_wr_data_r;
  logic [15:0] addr_q[$];
  logic [15:0] data_q[$];
  int n_fail = 0, tests_run = 0, seed = 54969;
  always #5 sys_clk = ~sys_clk;
  glyph_link_if lnk (.sys_clk(sys_clk));
  glyph_cmd_host u_glyph_cmd_host (.sys_clk(sys_clk), .rst(rst), .lnk(lnk),
    .font_rom_off(font_rom_off), .one_bpp_mode(one_bpp_mode),
    .op_valid(op_valid), .op_load(op_load), .op_value(op_value),
    .op_rows(op_rows), .row_valid(row_valid), .row_data(row_data),
    .op_ready_r(op_ready_r), .op_refused_r(op_refused_r),
    .row_ready_r(row_ready_r));
  glyph_ram_address_gen u_glyph_ram_address_gen (.sys_clk(sys_clk),
    .rst(rst), .lnk(lnk), .font_rom_off(font_rom_off),
    .char_lines(char_lines), .fetch_req(fetch_req), .fetch_code(fetch_code),
    .fetch_row(fetch_row), .fetch_valid_r(fetch_valid_r),
    .fetch_from_ram_r(fetch_from_ram_r), .fetch_addr_r(fetch_addr_r),
    .rom_fetch_r(rom_fetch_r), .rom_index_r(rom_index_r),
    .mem_wr_en_r(mem_wr_en_r), .mem_wr_addr_r(mem_wr_addr_r),
    .mem_wr_data_r(mem_wr_data_r), .glyph_table_base_r(glyph_table_base_r),
    .cursor_addr_r(cursor_addr_r));
  glyph_link_checker u_glyph_link_checker (.sys_clk(sys_clk), .rst(rst),
    .wr_valid(lnk.wr_valid), .wr_is_cmd(lnk.wr_is_cmd),
    .wr_data(lnk.wr_data), .fetch_req(fetch_req), .fetch_code(fetch_code),
    .fetch_row(fetch_row), .char_lines(char_lines),
    .font_rom_off(font_rom_off), .fetch_valid_r(fetch_valid_r),
    .fetch_from_ram_r(fetch_from_ram_r), .fetch_addr_r(fetch_addr_r),
    .rom_fetch_r(rom_fetch_r), .glyph_table_base_r(glyph_table_base_r),
    .mem_wr_en_r(mem_wr_en_r));
  task automatic chk(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d failed %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hang;
    chk("wait", 16'h1, 16'h0);
    give_verdict;
  endtask
  function automatic logic [15:0] exp_addr(logic [7:0] c, logic [3:0] r,
      logic [4:0] l);
    return (l > 5'h08) ? base + {4'h0, c, r} : base + {5'h00, c, r[2:0]};
  endfunction
  task automatic wait_ready;
    int k;
    for (k = 0; k < 64 && op_ready_r !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (k == 64) hang;
  endtask
  task automatic op(input logic ld, input logic [15:0] v, input logic [4:0] n);
    wait_ready;
    op_valid = 1'b1;
    op_load = ld;
    op_value = v;
    op_rows = n;
    @(posedge sys_clk);
    #1 op_valid = 1'b0;
  endtask
  task automatic base_set(input logic [15:0] v, exp);
    op(1'b0, v, 5'h00);
    wait_ready;
    repeat (2) @(posedge sys_clk);
    #1 chk("base", exp, glyph_table_base_r);
  endtask
  task automatic load(input logic [15:0] a, input logic [4:0] n);
    int k;
    op(1'b1, a, n);
    for (int i = 0; i < n; i++) begin
      row_data = 8'($random(seed));
      addr_q.push_back(a + 16'(i));
      data_q.push_back({8'h00, row_data});
      row_valid = 1'b1;
      // Host takes the byte at the edge after row_ready_r is seen high
      for (k = 0; k < 64 && row_ready_r !== 1'b1; k++) begin
        @(posedge sys_clk);
        #1;
      end
      if (k == 64) hang;
      @(posedge sys_clk);
      #1;
    end
    row_valid = 1'b0;
    wait_ready;
    repeat (2) @(posedge sys_clk);
    #1 chk("cursor", a + 16'(n), cursor_addr_r);
  endtask
  // Leaves fetch_req high so calls run back to back
  task automatic fetch(input logic [7:0] c, input logic [3:0] r,
      input logic [4:0] l);
    logic ram;
    ram = font_rom_off || c[7:5] == 3'h4 || c[7:5] == 3'h7;
    fetch_req = 1'b1;
    fetch_code = c;
    fetch_row = r;
    char_lines = l;
    @(posedge sys_clk);
    #1 chk("valid", 16'h1, {15'h0, fetch_valid_r});
    chk("addr", exp_addr(c, r, l), fetch_addr_r);
    chk("ram", {15'h0, ram}, {15'h0, fetch_from_ram_r});
    chk("rom", {15'h0, !ram}, {15'h0, rom_fetch_r});
    chk("index", {4'h0, c, r}, {4'h0, rom_index_r});
  endtask
  // Writes land one edge after each row byte; compare mid-cycle, in order
  always @(negedge sys_clk) begin
    if (!rst && mem_wr_en_r === 1'b1) begin
      chk("wr_addr", addr_q.pop_front(), mem_wr_addr_r);
      chk("wr_data", data_q.pop_front(), {8'h00, mem_wr_data_r});
    end
  end
  initial begin
    logic [7:0] corner[8];
    corner = '{8'h00, 8'h7F, 8'h80, 8'h9F, 8'hA0, 8'hDF, 8'hE0, 8'hFF};
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    base = 16'h4000;
    base_set(base, base);
    foreach (corner[i]) begin
      fetch(corner[i], 4'h7, 5'h08);
      fetch(corner[i], 4'hF, 5'h09);
    end
    fetch_req = 1'b0;
    load(16'h4800, 5'h10);
    load(16'h1234, 5'h00);
    one_bpp_mode = 1'b0;
    op(1'b1, 16'h0100, 5'h02);
    chk("refused", 16'h1, {15'h0, op_refused_r});
    one_bpp_mode = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 chk("idle", 16'h1, {15'h0, op_ready_r});
    chk("kept", 16'h1234, cursor_addr_r);
    font_rom_off = 1'b1;
    base = 16'h0000;
    base_set(16'h1234, base);
    repeat (6) fetch(8'($random(seed)), 4'($random(seed)), 5'h10);
    fetch_req = 1'b0;
    font_rom_off = 1'b0;
    repeat (4) begin
      base = 16'($random(seed));
      base_set(base, base);
      repeat (20) fetch(8'($random(seed)), 4'($random(seed)),
        5'h01 + 5'($random(seed) & 15));
      fetch_req = 1'b0;
      load(16'($random(seed)), 5'h01 + 5'($random(seed) & 15));
    end
    chk("left", 16'h0, 16'(addr_q.size()));
    give_verdict;
  end
endmodule
`default_nettype wire
